/* File: core/pld_pkg.sv */
// Constants, register map and types for the lock detector and status pin selector
package pld_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_LOCK_CFG = 8'h15;
    localparam logic [7:0] REG_STATUS = 8'h30;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h31;
    localparam logic [7:0] REG_IRQ_MASK = 8'h32;
    localparam logic [7:0] REG_COUNT_LO = 8'h33;
    localparam logic [7:0] REG_COUNT_HI = 8'h34;
    localparam logic [7:0] LOCK_CFG_RESET = 8'h00;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 4;
    localparam int WIN_BIT = 3;
    localparam int MODE_BIT = 2;
    localparam int ACC_MSB = 1;
    localparam int ACC_LSB = 0;
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] LOCK_THR_ACC0 = 10'h07f;
    localparam logic [9:0] LOCK_THR_ACC1 = 10'h0ff;
    localparam logic [9:0] LOCK_THR_ACC2 = 10'h1ff;
    localparam logic [9:0] LOCK_THR_ACC3 = 10'h3ff;
    localparam logic [9:0] LOCK_HYST = 10'h010;
    localparam logic [1:0] ACC_SEL1 = 2'h1;
    localparam logic [1:0] ACC_SEL2 = 2'h2;
    localparam logic [1:0] ACC_SEL3 = 2'h3;
    localparam int WIN_W = 3;
    localparam logic [2:0] WIN_NARROW = 3'h2;
    localparam logic [2:0] WIN_WIDE = 3'h4;
    localparam int IRQ_W = 4;
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOSS = 1;
    localparam int IRQ_CAL_DONE = 2;
    localparam int IRQ_SEQ_FAULT = 3;
    localparam int STAT_SUSTAINED = 0;
    localparam int STAT_MOMENTARY = 1;
    localparam int STAT_CARRIER = 2;
    localparam int STAT_CAL_DONE = 3;
    localparam int STAT_SEQ_FAULT = 4;
    localparam int SRC_N = 16;
    localparam int SRC_LOW = 0;
    localparam int SRC_HIGH = 1;
    localparam int SRC_SUSTAINED = 2;
    localparam int SRC_MOMENTARY = 3;
    localparam int SRC_CARRIER = 4;
    localparam int SRC_CAL_DONE = 5;
    localparam int SRC_SEQ_FAULT = 6;
    localparam int SRC_XTAL = 7;
    localparam int SRC_REF_CLK = 8;
    localparam int SRC_FILTER_CLK = 9;
    localparam int SRC_DECIMATOR_CLK = 10;
    localparam int SRC_PRE_CLK = 11;
    localparam int SRC_DELTA_SIGMA_CLK = 12;
    localparam int SRC_DEMOD_CLK = 13;
    localparam int SRC_OSC_CAL = 14;
    localparam int SRC_FREQ_CMP = 15;
    typedef enum logic [1:0] {CMP_IDLE, CMP_WAIT, CMP_LATE} pld_cmp_state_t;
endpackage

/* File: core/pld_cmp_if.sv */
// Phase comparison result passed from the window comparator to the lock counter
`timescale 1ns/1ps
interface pld_cmp_if;
    logic valid;
    logic in_window;
    modport src (output valid, output in_window);
    modport snk (input valid, input in_window);
endinterface

/* File: core/pld_phase_window.sv */
// Phase comparator: classifies each reference/feedback edge pair by window
`timescale 1ns/1ps
module pld_phase_window (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic prescaler_tick,
    input wire logic ref_edge,
    input wire logic fb_edge,
    input wire logic wide_window,
    pld_cmp_if.src cmp
);
    import pld_pkg::*;

    pld_cmp_state_t state, next_state;
    logic waiting_fb, next_waiting_fb;
    logic [WIN_W-1:0] gap, next_gap;
    logic result_valid, next_result_valid;
    logic result_in, next_result_in;
    wire logic [WIN_W-1:0] win_width;
    wire logic other_edge;
    wire logic [WIN_W-1:0] gap_inc;

    assign win_width = wide_window ? WIN_WIDE : WIN_NARROW;
    assign other_edge = waiting_fb ? fb_edge : ref_edge;
    assign gap_inc = gap + 3'h1;

    always_comb begin
        next_state = state;
        next_waiting_fb = waiting_fb;
        next_gap = gap;
        next_result_valid = 1'b0;
        next_result_in = result_in;
        unique case (state)
            CMP_IDLE: begin
                next_gap = '0;
                if (ref_edge && fb_edge) begin
                    next_result_valid = 1'b1;
                    next_result_in = 1'b1;
                end else if (ref_edge || fb_edge) begin
                    next_state = CMP_WAIT;
                    next_waiting_fb = ref_edge;
                end
            end
            CMP_WAIT: begin
                // In window when gap below width
                if (other_edge) begin
                    next_result_valid = 1'b1;
                    next_result_in = (gap < win_width);
                    next_state = CMP_IDLE;
                end else if (prescaler_tick) begin
                    if (gap_inc >= win_width) begin
                        next_result_valid = 1'b1;
                        next_result_in = 1'b0;
                        next_state = CMP_LATE;
                    end else begin
                        next_gap = gap_inc;
                    end
                end
            end
            CMP_LATE: begin
                // The late edge only closes the pair, it is already judged
                if (other_edge) begin
                    next_state = CMP_IDLE;
                end
            end
            default: begin
                next_state = CMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= CMP_IDLE;
            waiting_fb <= 1'b0;
            gap <= '0;
            result_valid <= 1'b0;
            result_in <= 1'b0;
        end else begin
            state <= next_state;
            waiting_fb <= next_waiting_fb;
            gap <= next_gap;
            result_valid <= next_result_valid;
            result_in <= next_result_in;
        end
    end

    assign cmp.valid = result_valid;
    assign cmp.in_window = result_in;
endmodule

/* File: core/pld_lock_counter.sv */
// Lock counter with selectable counting style and hysteretic thresholds
`timescale 1ns/1ps
module pld_lock_counter (
    input wire logic clk,
    input wire logic reset_n,
    pld_cmp_if.snk cmp,
    input wire logic updown_mode,
    input wire logic [1:0] accuracy,
    output logic [pld_pkg::CNT_W-1:0] count,
    output logic lock_sustained,
    output logic lock_momentary
);
    import pld_pkg::*;

    logic [CNT_W-1:0] next_count;
    logic next_sustained;
    wire logic [CNT_W-1:0] lock_thr;
    wire logic [CNT_W-1:0] loss_thr;
    wire logic [CNT_W-1:0] count_up;
    wire logic [CNT_W-1:0] count_down;
    wire logic [CNT_W-1:0] count_miss;

    // Thresholds for accuracy 0 and 1
    // Thresholds for accuracy 2 and 3
    assign lock_thr = (accuracy == ACC_SEL3) ? LOCK_THR_ACC3 :
                      (accuracy == ACC_SEL2) ? LOCK_THR_ACC2 :
                      (accuracy == ACC_SEL1) ? LOCK_THR_ACC1 : LOCK_THR_ACC0;
    assign loss_thr = lock_thr - LOCK_HYST;

    assign count_up = (count == CNT_MAX) ? count : count + 10'h001;
    assign count_down = (count == CNT_ZERO) ? count : count - 10'h001;
    // Restart mode clears on a miss
    // Up/down mode steps down on a miss
    assign count_miss = updown_mode ? count_down : CNT_ZERO;

    always_comb begin
        next_count = count;
        if (cmp.valid) begin
            next_count = cmp.in_window ? count_up : count_miss;
        end
        next_sustained = lock_sustained;
        if (count >= lock_thr) begin
            next_sustained = 1'b1;
        end else if (count <= loss_thr) begin
            next_sustained = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= CNT_ZERO;
            lock_sustained <= 1'b0;
            lock_momentary <= 1'b0;
        end else begin
            count <= next_count;
            lock_sustained <= next_sustained;
            if (cmp.valid) begin
                lock_momentary <= cmp.in_window;
            end
        end
    end
endmodule

/* File: core/pld_lock_detect_top.sv */
// Lock detector with status pin selector, register port and interrupt
//
// Contract
// - Selector 0 drives low, 1 drives high
// - Selectors 2, 3 give lock flags, active low
// - Selector 4: low while carrier is sensed
// - Selectors 5, 6: calibration, fault, active low
// - Window two or four prescaler cycles wide
// - Style 0: counter restarts on a miss
// - Style 1: count up hits, down misses
// - Accuracy 0, 1: lock 127/111, 255/239
// - Accuracy 2, 3: lock 511/495, 1023/1007
// - Sixteen counts of hysteresis between thresholds
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module pld_lock_detect_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [pld_pkg::ADDR_W-1:0] addr,
    input wire logic [pld_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [pld_pkg::DATA_W-1:0] rd_data,
    input wire logic prescaler_tick,
    input wire logic ref_edge,
    input wire logic fb_edge,
    input wire logic rssi_above_cs,
    input wire logic cal_complete,
    input wire logic sequencing_fault,
    input wire logic crystal_osc_clk,
    input wire logic ref_clk,
    input wire logic filter_clk,
    input wire logic decimator_clk,
    input wire logic prescaler_clk,
    input wire logic delta_sigma_clk,
    input wire logic demodulator_clk,
    input wire logic oscillator_cal_compare,
    input wire logic freq_compare,
    output logic lock_pin,
    output logic irq
);
    import pld_pkg::*;

    logic [DATA_W-1:0] lock_detect_and_pin_select;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_status;
    logic [DATA_W-1:0] next_rd_data;
    logic next_lock_pin;
    logic sustained_d;
    logic cal_d;
    logic fault_d;

    wire logic [CNT_W-1:0] lock_count;
    wire logic pll_lock_sustained;
    wire logic pll_lock_momentary;
    wire logic [3:0] pin_select;
    wire logic wide_window;
    wire logic updown_mode;
    wire logic [1:0] accuracy;
    wire logic [SRC_N-1:0] pin_src;
    wire logic [IRQ_W-1:0] events;
    wire logic [IRQ_W-1:0] irq_clear;
    wire logic [DATA_W-1:0] status_word;
    wire logic [DATA_W-1:0] count_lo;
    wire logic [DATA_W-1:0] count_hi;
    wire logic wr_cfg;
    wire logic wr_irq_status;
    wire logic wr_irq_mask;

    pld_cmp_if cmp_link ();

    // Configuration fields
    assign pin_select = lock_detect_and_pin_select[SEL_MSB:SEL_LSB];
    assign wide_window = lock_detect_and_pin_select[WIN_BIT];
    assign updown_mode = lock_detect_and_pin_select[MODE_BIT];
    assign accuracy = lock_detect_and_pin_select[ACC_MSB:ACC_LSB];

    pld_phase_window u_window (
        .clk(clk),
        .reset_n(reset_n),
        .prescaler_tick(prescaler_tick),
        .ref_edge(ref_edge),
        .fb_edge(fb_edge),
        .wide_window(wide_window),
        .cmp(cmp_link.src)
    );

    pld_lock_counter u_counter (
        .clk(clk),
        .reset_n(reset_n),
        .cmp(cmp_link.snk),
        .updown_mode(updown_mode),
        .accuracy(accuracy),
        .count(lock_count),
        .lock_sustained(pll_lock_sustained),
        .lock_momentary(pll_lock_momentary)
    );

    assign pin_src[SRC_LOW] = 1'b0;
    assign pin_src[SRC_HIGH] = 1'b1;
    assign pin_src[SRC_SUSTAINED] = ~pll_lock_sustained;
    assign pin_src[SRC_MOMENTARY] = ~pll_lock_momentary;
    assign pin_src[SRC_CARRIER] = ~rssi_above_cs;
    assign pin_src[SRC_CAL_DONE] = ~cal_complete;
    assign pin_src[SRC_SEQ_FAULT] = ~sequencing_fault;
    // Internal clocks and comparators in order
    assign pin_src[SRC_XTAL] = crystal_osc_clk;
    assign pin_src[SRC_REF_CLK] = ref_clk;
    assign pin_src[SRC_FILTER_CLK] = filter_clk;
    assign pin_src[SRC_DECIMATOR_CLK] = decimator_clk;
    assign pin_src[SRC_PRE_CLK] = prescaler_clk;
    assign pin_src[SRC_DELTA_SIGMA_CLK] = delta_sigma_clk;
    assign pin_src[SRC_DEMOD_CLK] = demodulator_clk;
    assign pin_src[SRC_OSC_CAL] = oscillator_cal_compare;
    assign pin_src[SRC_FREQ_CMP] = freq_compare;

    // Pin is registered: routed clocks are sampled, so only slow ones survive
    assign next_lock_pin = pin_src[pin_select];

    // Register port decode
    assign wr_cfg = wr_en && (addr == REG_LOCK_CFG);
    assign wr_irq_status = wr_en && (addr == REG_IRQ_STATUS);
    assign wr_irq_mask = wr_en && (addr == REG_IRQ_MASK);

    assign status_word = {3'h0, sequencing_fault, cal_complete, rssi_above_cs,
                          pll_lock_momentary, pll_lock_sustained};
    assign count_lo = lock_count[DATA_W-1:0];
    assign count_hi = {6'h00, lock_count[CNT_W-1:DATA_W]};

    // Both edges of lock and rising edges of calibration done and fault are events
    assign events[IRQ_LOCK_GAIN] = pll_lock_sustained & ~sustained_d;
    assign events[IRQ_LOCK_LOSS] = ~pll_lock_sustained & sustained_d;
    assign events[IRQ_CAL_DONE] = cal_complete & ~cal_d;
    assign events[IRQ_SEQ_FAULT] = sequencing_fault & ~fault_d;

    // Write one to clear; a new event in the same cycle wins
    assign irq_clear = wr_irq_status ? wr_data[IRQ_W-1:0] : 4'h0;
    assign next_irq_status = (irq_status & ~irq_clear) | events;
    assign irq = |(irq_status & irq_mask);

    always_comb begin
        next_rd_data = '0;
        if (rd_en) begin
            unique case (addr)
                REG_LOCK_CFG: next_rd_data = lock_detect_and_pin_select;
                REG_STATUS: next_rd_data = status_word;
                REG_IRQ_STATUS: next_rd_data = {4'h0, irq_status};
                REG_IRQ_MASK: next_rd_data = {4'h0, irq_mask};
                REG_COUNT_LO: next_rd_data = count_lo;
                REG_COUNT_HI: next_rd_data = count_hi;
                default: next_rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_detect_and_pin_select <= LOCK_CFG_RESET;
        end else if (wr_cfg) begin
            // Any value accepted; narrow restart is the reset default
            lock_detect_and_pin_select <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= IRQ_MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask <= wr_data[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= '0;
            sustained_d <= 1'b0;
            cal_d <= 1'b0;
            fault_d <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            sustained_d <= pll_lock_sustained;
            cal_d <= cal_complete;
            fault_d <= sequencing_fault;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= '0;
            lock_pin <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            lock_pin <= next_lock_pin;
        end
    end
endmodule

/* File: tb/pld_pll_model.sv */
// Reference and feedback edge source that stands in for the synthesizer dividers
`timescale 1ns/1ps
module pld_pll_model (
    input wire logic clk,
    output logic ref_edge,
    output logic fb_edge,
    output logic prescaler_tick
);
    initial begin
        ref_edge = 1'b0;
        fb_edge = 1'b0;
        prescaler_tick = 1'b0;
    end

    // ticks counted between edges
    // One reference and one feedback edge make one comparison; zero ticks means same cycle
    task automatic pair(input int ticks);
        @(posedge clk);
        ref_edge <= 1'b1;
        fb_edge <= (ticks == 0);
        repeat (ticks) begin
            @(posedge clk);
            ref_edge <= 1'b0;
            prescaler_tick <= 1'b1;
        end
        if (ticks > 0) begin
            @(posedge clk);
            prescaler_tick <= 1'b0;
            fb_edge <= 1'b1;
        end
        @(posedge clk);
        ref_edge <= 1'b0;
        fb_edge <= 1'b0;
        // Leave room for result, count, flag and pin stages to settle
        repeat (4) @(posedge clk);
    endtask
endmodule

/* File: tb/pld_lock_detect_monitor.sv */
// Port-level checks on the lock detector, attached to its top module
`timescale 1ns/1ps
module pld_lock_detect_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [pld_pkg::ADDR_W-1:0] addr,
    input wire logic [pld_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [pld_pkg::DATA_W-1:0] rd_data,
    input wire logic rssi_above_cs,
    input wire logic cal_complete,
    input wire logic sequencing_fault,
    input wire logic crystal_osc_clk,
    input wire logic ref_clk,
    input wire logic filter_clk,
    input wire logic decimator_clk,
    input wire logic prescaler_clk,
    input wire logic delta_sigma_clk,
    input wire logic demodulator_clk,
    input wire logic oscillator_cal_compare,
    input wire logic freq_compare,
    input wire logic lock_pin,
    input wire logic irq
);
    import pld_pkg::*;
    logic [7:0] cfg;
    logic [3:0] mask;
    wire [3:0] sel = cfg[SEL_MSB:SEL_LSB];
    wire [2:0] st = {sequencing_fault, cal_complete, rssi_above_cs};
    // Lock flags are internal, so slots 2 and 3 are left as don't-care zeros
    wire [15:0] route = {freq_compare, oscillator_cal_compare, demodulator_clk, delta_sigma_clk,
        prescaler_clk, decimator_clk, filter_clk, ref_clk, crystal_osc_clk, ~st, 4'h2};
    wire unmapped = !(addr == REG_LOCK_CFG || (addr >= REG_STATUS && addr <= REG_COUNT_HI));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= LOCK_CFG_RESET;
            mask <= IRQ_MASK_RESET;
        end else if (wr_en && addr == REG_LOCK_CFG) begin
            cfg <= wr_data;
        end else if (wr_en && addr == REG_IRQ_MASK) begin
            mask <= wr_data[3:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_cfg_rd;
        rd_en && addr == REG_LOCK_CFG;
    endsequence
    sequence s_status_rd;
        rd_en && addr == REG_STATUS && $stable(st);
    endsequence

    a_const_level: assert property (
        sel < 4'h2 |=> lock_pin == $past(route[sel]))
        else $error("pin not at constant level");
    a_active_low: assert property (
        sel >= 4'h4 && sel <= 4'h6 |=> lock_pin == $past(route[sel]))
        else $error("pin not inverse of flag");
    a_clk_route: assert property (
        sel >= 4'h7 |=> lock_pin == $past(route[sel]))
        else $error("pin not following routed signal");
    a_cfg_readback: assert property (
        s_cfg_rd |=> rd_data == $past(cfg))
        else $error("config read mismatch");
    a_idle_rdzero: assert property (
        !rd_en |=> rd_data == 8'h00)
        else $error("read data not zero when idle");
    a_unmapped_zero: assert property (
        rd_en && unmapped |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_status_read: assert property (
        s_status_rd |=> rd_data[4:2] == $past(st))
        else $error("status flags mismatch");
    a_irq_masked: assert property (
        mask == 4'h0 |-> !irq)
        else $error("interrupt with all sources masked");
endmodule

bind pld_lock_detect_top pld_lock_detect_monitor u_mon (.*);

/* File: tb/tb.sv */
// Self-checking bench for the lock detector and status pin selector
`timescale 1ns/1ps
module tb;
    import pld_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [11:0] lvl = 12'h000;
    wire [7:0] rd_data;
    wire ref_edge, fb_edge, prescaler_tick, lock_pin, irq;
    wire rssi_above_cs, cal_complete, sequencing_fault, crystal_osc_clk, ref_clk;
    wire filter_clk, decimator_clk, prescaler_clk, delta_sigma_clk, demodulator_clk;
    wire oscillator_cal_compare, freq_compare;
    int fails = 0;
    int tests_run = 0;

    assign {freq_compare, oscillator_cal_compare, demodulator_clk, delta_sigma_clk, prescaler_clk,
        decimator_clk, filter_clk, ref_clk, crystal_osc_clk, sequencing_fault, cal_complete,
        rssi_above_cs} = lvl;

    always #10 clk = ~clk;

    pld_pll_model u_pll (.*);
    pld_lock_detect_top u_dut (.*);

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so it is taken there
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data & m, e);
    endtask

    task automatic pin(input logic e);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, lock_pin}, {7'h00, e});
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #2000000;
        fails++;
        end_sim;
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(REG_LOCK_CFG, 8'h00, 8'hff);
        pin(1'b0);
        $display("test reset done");
        for (int s = 0; s < 16; s++) begin
            if (s == 2 || s == 3)
                continue;
            wr(REG_LOCK_CFG, 8'(s << 4));
            for (int v = 0; v < 2; v++) begin
                // Whole-vector write on the edge: one source toggles, the rest stay low
                @(posedge clk);
                if (s > 3)
                    lvl <= 12'(v) << (s - 4);
                pin(s < 2 ? s[0] : (s < 7 ? !v[0] : v[0]));
            end
        end
        @(posedge clk);
        lvl <= 12'h000;
        wr(REG_STATUS, 8'hff);
        rd(8'h7e, 8'h00, 8'hff);
        rd(REG_STATUS, 8'h00, 8'h1c);
        $display("test pin selector done");
        for (int a = 0; a < 4; a++) begin
            wr(REG_LOCK_CFG, 8'h20 | 8'(a));
            u_pll.pair(8);
            repeat ((128 << a) - 2) u_pll.pair(0);
            rd(REG_STATUS, 8'h00, 8'h01);
            u_pll.pair(0);
            rd(REG_STATUS, 8'h01, 8'h01);
            rd(REG_COUNT_LO, 8'((128 << a) - 1), 8'hff);
            rd(REG_COUNT_HI, 8'(((128 << a) - 1) >> 8), 8'h03);
            pin(1'b0);
        end
        $display("test thresholds done");
        rd(REG_IRQ_STATUS, 8'h0f, 8'hff);
        chk({7'h00, irq}, 8'h00);
        wr(REG_IRQ_MASK, 8'h01);
        #1 chk({7'h00, irq}, 8'h01);
        wr(REG_IRQ_STATUS, 8'h0f);
        #1 chk({7'h00, irq}, 8'h00);
        rd(REG_IRQ_STATUS, 8'h00, 8'hff);
        rd(REG_IRQ_MASK, 8'h01, 8'hff);
        $display("test interrupt done");
        wr(REG_LOCK_CFG, 8'h20);
        u_pll.pair(8);
        wr(REG_LOCK_CFG, 8'h24);
        repeat (127) u_pll.pair(0);
        repeat (15) u_pll.pair(8);
        rd(REG_COUNT_LO, 8'h70, 8'hff);
        rd(REG_STATUS, 8'h01, 8'h03);
        u_pll.pair(8);
        rd(REG_COUNT_LO, 8'h6f, 8'hff);
        rd(REG_STATUS, 8'h00, 8'h03);
        pin(1'b1);
        wr(REG_LOCK_CFG, 8'h34);
        u_pll.pair(0);
        pin(1'b0);
        $display("test hysteresis done");
        for (int i = 0; i < 4; i++) begin
            wr(REG_LOCK_CFG, i[1] ? 8'h38 : 8'h30);
            u_pll.pair(1 + 2 * i[0] + 2 * i[1]);
            pin(i[0]);
        end
        $display("test window done");
        end_sim;
    end
endmodule
